// ### rpka_engine.sv
/*
  Replay-protected partition engine: key programming, result readback and
  authenticated counter read over 512-byte frames on an 8-lane link.
  Assumes an external HMAC core, a command decoder that posts the partition
  switch, block count and commands over APB, and a host link clock far slower
  than pclk.
*/
// The implementer's own choices: the APB register port and the register offsets.
// Behaviour
// - Failed access: zero data, general failure
// - Report only the first error found
// - Key write needs count one, reliable
// - Busy while key stored; status generic
// - Result request needs count one
// - Busy, then count-one read returns result
// - Key result response type 0x0100
// - No key: report code 0x07
// - Key store fail 0x05, else 0x01
// - Counter request needs count one, nonce
// - Busy, then count-one read returns counter
// - Counter response: nonce, counter, MAC, result
// - Counter read fail 0x06, else 0x01
// - Expired counter sets result bit 7
// - MAC over bytes 283..0 with key
// - Counter saturates at all ones
// - Key is write-once and unreadable
`timescale 1ns/1ps
module rpka_engine (
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave.
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  // Frame link.
  input  wire logic         link_clk,
  input  wire logic [7:0]   link_dat_in,
  output logic      [7:0]   link_dat_out,
  output logic      [7:0]   link_dat_oe,
  // HMAC core.
  output logic              mac_start,
  output logic      [255:0] mac_key,
  output logic      [7:0]   mac_byte,
  output logic              mac_byte_valid,
  output logic              mac_byte_last,
  input  wire logic         mac_done,
  input  wire logic [255:0] mac_value,
  // Storage events.
  input  wire logic         counter_inc,
  input  wire logic         key_store_fail,
  input  wire logic         counter_read_fail
);
  rpka_pkg::rpka_state_t state;
  rpka_pkg::rpka_job_t   job;
  logic [8:0]   sync_q;
  logic         lclk_d;
  logic [9:0]   beat;
  logic [4:0]   stat_sh;
  logic [2:0]   stat_cnt;
  logic         frame_ok;
  logic [7:0]   busy_cnt;
  logic [9:0]   midx;
  logic         mac_run;
  logic [2:0]   part;
  logic [15:0]  blk_cnt;
  logic         blk_rel;
  logic         cnt_valid;
  logic         wfail;
  logic         wrel;
  logic         rx_bad;
  logic [15:0]  rx_type;
  logic [127:0] rx_nonce;
  logic         key_set;
  logic [7:0]   op_result;
  logic [15:0]  last_type;
  logic [15:0]  resp_type;
  logic [7:0]   resp_res;
  logic [31:0]  resp_cnt;
  logic [255:0] resp_mac;
  logic         pend;
  logic         tx_fail;
  logic [31:0]  counter;
  logic [7:0]   crc_msb;
  logic         crc_zero;

  rpka_sync u_sync (
    .clk  (pclk),
    .rstn (presetn),
    .d    ({link_clk, link_dat_in}),
    .q    (sync_q)
  );

  wire [7:0] ldat  = sync_q[7:0];
  wire       lrise = sync_q[8] & ~lclk_d;
  wire       lfall = ~sync_q[8] & lclk_d;
  wire expired = (counter == rpka_pkg::COUNTER_MAX);

  // Response byte k of the outgoing frame; fields not sent read as zero.
  function automatic logic [7:0] fbyte(input logic [9:0] k);
    logic [9:0] dn;
    logic [9:0] dm;
    logic       cnt_resp;
    dn       = k - rpka_pkg::BYTE_NONCE_LO;
    dm       = k - rpka_pkg::BYTE_MAC_LO;
    cnt_resp = (resp_type == rpka_pkg::RESP_COUNTER) & ~tx_fail;
    fbyte    = 8'h00;
    if (k == 10'h000)
      fbyte = resp_type[7:0];
    else if (k == 10'h001)
      fbyte = resp_type[15:8];
    else if (k == rpka_pkg::BYTE_RES)
      fbyte = (tx_fail ? rpka_pkg::RES_GENERAL : resp_res) | (expired ? rpka_pkg::RES_EXPIRED : 8'h00);
    else if (cnt_resp && k >= rpka_pkg::BYTE_CNT_LO && k <= rpka_pkg::BYTE_CNT_HI)
      fbyte = resp_cnt[{k[1:0], 3'b000} +: 8];
    else if (cnt_resp && k >= rpka_pkg::BYTE_NONCE_LO && k <= rpka_pkg::BYTE_NONCE_HI)
      fbyte = rx_nonce[{dn[3:0], 3'b000} +: 8];
    else if (cnt_resp && k >= rpka_pkg::BYTE_MAC_LO && k <= rpka_pkg::BYTE_MAC_HI)
      fbyte = resp_mac[{dm[4:0], 3'b000} +: 8];
  endfunction : fbyte

  // APB decode; a write takes effect at the edge where pready is sampled high.
  wire apb_setup = psel & penable & ~pready;
  wire apb_done  = psel & penable & pready;
  wire hit_part  = (paddr == rpka_pkg::REG_PART);
  wire hit_blk   = (paddr == rpka_pkg::REG_BLKCNT);
  wire hit_cmd   = (paddr == rpka_pkg::REG_CMD);
  wire hit_stat  = (paddr == rpka_pkg::REG_STATUS);
  wire hit_cnt   = (paddr == rpka_pkg::REG_COUNTER);
  wire mapped    = hit_part | hit_blk | hit_cmd | hit_stat | hit_cnt;
  wire is_wr25   = (pwdata[5:0] == rpka_pkg::CMD_WRITE_MULTI);
  wire is_rd18   = (pwdata[5:0] == rpka_pkg::CMD_READ_MULTI);
  wire cmd_ok    = (state == rpka_pkg::ST_IDLE) & (part == rpka_pkg::PART_REPLAY) & (is_wr25 | is_rd18);
  wire refuse    = ~mapped | (pwrite & hit_cmd & ~cmd_ok);
  wire wr_ok     = apb_done & pwrite & ~pslverr;
  wire part_wr   = wr_ok & hit_part;
  wire blk_wr    = wr_ok & hit_blk;
  wire cmd25_go  = wr_ok & hit_cmd & is_wr25;
  wire cmd18_go  = wr_ok & hit_cmd & is_rd18;

  // Status shows the state, key_set, expired and the pending response type, never a result code.
  wire [31:0] stat_word = {pend ? resp_type : 16'h0000, 11'h000, expired, key_set, state};
  wire [31:0] blk_word  = {blk_rel, cnt_valid, 14'h0000, blk_cnt};
  wire [31:0] rd_mux    = hit_part ? {29'h00000000, part} :
                          hit_blk  ? blk_word :
                          hit_stat ? stat_word :
                          hit_cnt  ? counter : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      part    <= rpka_pkg::PART_RESET;
    end
    else
    begin
      pready  <= apb_setup;
      pslverr <= apb_setup & refuse;
      prdata  <= (apb_setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (part_wr)
        part <= pwdata[2:0];
    end
  end

  // Frame checks; the first failing check decides the outcome.
  wire rx_beat   = lrise & (state == rpka_pkg::ST_RXDATA);
  wire [9:0] rxk = rpka_pkg::BYTE_LAST - beat;
  wire rx_dat    = rx_beat & (beat <= rpka_pkg::RX_DATA_LAST);
  wire rx_last   = rx_beat & (beat == rpka_pkg::RX_END);
  wire rx_ok     = crc_zero & (ldat == 8'hFF);
  wire key_req   = (rx_type == rpka_pkg::REQ_KEY_PROG);
  wire rel_bad   = key_req & ~wrel;
  wire req_fail  = wfail | rel_bad | rx_bad;
  wire mac_path  = (job == rpka_pkg::JOB_COUNTER) & key_set;
  wire in_busy   = (state == rpka_pkg::ST_BUSY);
  localparam logic [7:0] SHORT_ONE = rpka_pkg::SHORT_BUSY_CYC;
  wire busy_done = in_busy & (mac_path ? (mac_done & ~mac_run) : (busy_cnt == SHORT_ONE));

  wire [7:0] tx_byte = (beat <= rpka_pkg::TX_DATA_LAST) ? fbyte(rpka_pkg::TX_DATA_LAST - beat) : crc_msb;
  wire tx_beat  = lfall & (state == rpka_pkg::ST_TXDATA);
  wire crc_en   = (rx_beat & (beat < rpka_pkg::RX_END)) |
                  (tx_beat & (beat != 10'h000) & (beat <= rpka_pkg::TX_CRC_LAST));
  wire crc_clr  = cmd18_go | ((state == rpka_pkg::ST_RXWAIT) & lrise);

  rpka_crc16 u_crc (
    .clk  (pclk),
    .rstn (presetn),
    .clr  (crc_clr),
    .en   (crc_en),
    .din  ((state == rpka_pkg::ST_TXDATA) ? tx_byte : ldat),
    .msb  (crc_msb),
    .zero (crc_zero)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lclk_d <= 1'b0;
    else
      lclk_d <= sync_q[8];
  end

  // Link sequencer: receive, CRC status, busy, transmit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= rpka_pkg::ST_IDLE;
      beat         <= 10'h000;
      stat_sh      <= 5'h00;
      stat_cnt     <= 3'h0;
      frame_ok     <= 1'b0;
      busy_cnt     <= 8'h00;
      link_dat_out <= 8'hFF;
      link_dat_oe  <= 8'h00;
      tx_fail      <= 1'b0;
    end
    else
    begin
      case (state)
        rpka_pkg::ST_IDLE:
        begin
          beat <= 10'h000;
          if (cmd25_go)
            state <= rpka_pkg::ST_RXWAIT;
          else if (cmd18_go)
          begin
            state   <= rpka_pkg::ST_TXDATA;
            tx_fail <= ~cnt_valid | (blk_cnt != rpka_pkg::BLK_ONE) | ~pend;
          end
        end
        rpka_pkg::ST_RXWAIT:
          if (lrise && ldat == 8'h00)
            state <= rpka_pkg::ST_RXDATA;
        rpka_pkg::ST_RXDATA:
          if (rx_beat)
          begin
            beat <= beat + 10'h001;
            if (rx_last)
            begin
              state    <= rpka_pkg::ST_STATUS;
              frame_ok <= rx_ok;
              stat_sh  <= rx_ok ? rpka_pkg::STAT_POSITIVE : rpka_pkg::STAT_NEGATIVE;
              stat_cnt <= rpka_pkg::STAT_BITS;
            end
          end
        rpka_pkg::ST_STATUS:
          if (lfall)
          begin
            if (stat_cnt != 3'h0)
            begin
              link_dat_out <= {7'h7F, stat_sh[4]};
              link_dat_oe  <= 8'h01;
              stat_sh      <= {stat_sh[3:0], 1'b0};
              stat_cnt     <= stat_cnt - 3'h1;
            end
            else if (frame_ok)
            begin
              link_dat_out <= 8'hFE;
              state        <= rpka_pkg::ST_BUSY;
              busy_cnt     <= (job == rpka_pkg::JOB_KEY) ? rpka_pkg::KEY_BUSY_CYC : SHORT_ONE;
            end
            else
            begin
              link_dat_oe <= 8'h00;
              state       <= rpka_pkg::ST_IDLE;
            end
          end
        rpka_pkg::ST_BUSY:
        begin
          if (busy_cnt != 8'h00)
            busy_cnt <= busy_cnt - 8'h01;
          if (busy_done)
          begin
            link_dat_oe <= 8'h00;
            state       <= rpka_pkg::ST_IDLE;
          end
        end
        rpka_pkg::ST_TXDATA:
          if (tx_beat)
          begin
            beat        <= beat + 10'h001;
            link_dat_oe <= 8'hFF;
            if (beat == 10'h000)
              link_dat_out <= 8'h00;
            else if (beat <= rpka_pkg::TX_CRC_LAST)
              link_dat_out <= tx_byte;
            else if (beat == rpka_pkg::TX_END)
              link_dat_out <= 8'hFF;
            else
            begin
              link_dat_oe <= 8'h00;
              tx_fail     <= 1'b0;
              state       <= rpka_pkg::ST_IDLE;
            end
          end
        default:
          state <= rpka_pkg::ST_IDLE;
      endcase
    end
  end

  localparam logic [9:0] TX_END_PLUS = rpka_pkg::TX_END + 10'h001;
  // Request capture and decisions.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blk_cnt   <= 16'h0000;
      blk_rel   <= 1'b0;
      cnt_valid <= 1'b0;
      wfail     <= 1'b0;
      wrel      <= 1'b0;
      rx_bad    <= 1'b0;
      rx_type   <= 16'h0000;
      rx_nonce  <= 128'h0;
      mac_key   <= 256'h0;
      key_set   <= 1'b0;
      job       <= rpka_pkg::JOB_FAIL;
      op_result <= rpka_pkg::RES_NO_KEY;
      last_type <= rpka_pkg::RESP_KEY_PROG;
      resp_type <= rpka_pkg::RESP_NONE;
      resp_res  <= rpka_pkg::RES_OK;
      resp_cnt  <= 32'h00000000;
      resp_mac  <= 256'h0;
      pend      <= 1'b0;
    end
    else
    begin
      if (blk_wr)
      begin
        blk_cnt   <= pwdata[15:0];
        blk_rel   <= pwdata[rpka_pkg::BLK_RELIABLE];
        cnt_valid <= 1'b1;
      end
      else if (cmd25_go || cmd18_go)
        cnt_valid <= 1'b0;
      if (cmd25_go)
      begin
        wfail  <= ~cnt_valid | (blk_cnt != rpka_pkg::BLK_ONE);
        wrel   <= blk_rel;
        rx_bad <= 1'b0;
      end
      if (rx_dat)
      begin
        if (rxk >= rpka_pkg::BYTE_MAC_LO && rxk <= rpka_pkg::BYTE_MAC_HI && !key_set)
          mac_key <= {mac_key[247:0], ldat};
        if (rxk >= rpka_pkg::BYTE_NONCE_LO && rxk <= rpka_pkg::BYTE_NONCE_HI)
          rx_nonce <= {rx_nonce[119:0], ldat};
        if (rxk >= rpka_pkg::BYTE_RES && rxk <= rpka_pkg::BYTE_CNT_HI && ldat != 8'h00)
          rx_bad <= 1'b1;
        if (rxk <= 10'h001)
          rx_type <= {rx_type[7:0], ldat};
      end
      if (rx_last && rx_ok)
      begin
        pend <= 1'b0;
        if (req_fail)
        begin
          job       <= rpka_pkg::JOB_FAIL;
          op_result <= rpka_pkg::RES_GENERAL;
        end
        else if (key_req)
          job <= rpka_pkg::JOB_KEY;
        else if (rx_type == rpka_pkg::REQ_COUNTER)
        begin
          job       <= rpka_pkg::JOB_COUNTER;
          resp_type <= rpka_pkg::RESP_COUNTER;
          resp_cnt  <= counter;
          resp_mac  <= 256'h0;
          resp_res  <= !key_set ? rpka_pkg::RES_NO_KEY :
                       counter_read_fail ? rpka_pkg::RES_READ_FAIL : rpka_pkg::RES_OK;
        end
        else if (rx_type == rpka_pkg::REQ_RESULT)
        begin
          job       <= rpka_pkg::JOB_RESULT;
          resp_type <= last_type;
          resp_res  <= op_result;
        end
        else
        begin
          job       <= rpka_pkg::JOB_FAIL;
          op_result <= rpka_pkg::RES_GENERAL;
        end
      end
      if (busy_done)
      begin
        pend <= (job == rpka_pkg::JOB_COUNTER) | (job == rpka_pkg::JOB_RESULT);
        if (job == rpka_pkg::JOB_KEY)
        begin
          last_type <= rpka_pkg::RESP_KEY_PROG;
          if (key_set)
            op_result <= rpka_pkg::RES_GENERAL;
          else if (key_store_fail)
            op_result <= rpka_pkg::RES_WRITE_FAIL;
          else
          begin
            key_set   <= 1'b1;
            op_result <= rpka_pkg::RES_OK;
          end
        end
        if (mac_path)
          resp_mac <= mac_value;
      end
      else if (tx_beat && beat == TX_END_PLUS)
        pend <= 1'b0;
    end
  end

  // HMAC message feed: bytes 283 down to 0 of the counter response.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mac_start      <= 1'b0;
      mac_run        <= 1'b0;
      midx           <= 10'h000;
      mac_byte       <= 8'h00;
      mac_byte_valid <= 1'b0;
      mac_byte_last  <= 1'b0;
    end
    else
    begin
      mac_start      <= 1'b0;
      mac_byte_valid <= 1'b0;
      mac_byte_last  <= 1'b0;
      if (state == rpka_pkg::ST_STATUS && lfall && stat_cnt == 3'h0 && frame_ok && mac_path)
      begin
        mac_start <= 1'b1;
        mac_run   <= 1'b1;
        midx      <= rpka_pkg::BYTE_MSG_TOP;
      end
      else if (mac_run)
      begin
        mac_byte       <= fbyte(midx);
        mac_byte_valid <= 1'b1;
        mac_byte_last  <= (midx == 10'h000);
        midx           <= midx - 10'h001;
        if (midx == 10'h000)
          mac_run <= 1'b0;
      end
    end
  end

  // Write counter, bumped by the write path and held at its maximum.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      counter <= rpka_pkg::COUNTER_RESET;
    else if (counter_inc && !expired)
      counter <= counter + 32'h00000001;
  end
endmodule : rpka_engine

// ### rpka_pkg.sv
/*
  Constants and types shared by the replay-protected key and counter engine.
  Assumes a 40 MHz pclk and a frame link that carries 8 data lanes.
*/
package rpka_pkg;

  // Register byte offsets on the APB port.
  localparam logic [7:0]  REG_PART        = 8'h00;
  localparam logic [7:0]  REG_BLKCNT      = 8'h04;
  localparam logic [7:0]  REG_CMD         = 8'h08;
  localparam logic [7:0]  REG_STATUS      = 8'h0C;
  localparam logic [7:0]  REG_COUNTER     = 8'h10;

  // Register fields and reset values.
  localparam logic [2:0]  PART_RESET      = 3'h0;
  localparam logic [2:0]  PART_REPLAY     = 3'h3;
  localparam int          BLK_RELIABLE    = 31;
  localparam int          BLK_VALID       = 30;
  localparam logic [15:0] BLK_ONE         = 16'h0001;
  localparam logic [5:0]  CMD_WRITE_MULTI = 6'h19;
  localparam logic [5:0]  CMD_READ_MULTI  = 6'h12;

  // Request and response types.
  localparam logic [15:0] REQ_KEY_PROG    = 16'h0001;
  localparam logic [15:0] REQ_COUNTER     = 16'h0002;
  localparam logic [15:0] REQ_RESULT      = 16'h0005;
  localparam logic [15:0] RESP_NONE       = 16'h0000;
  localparam logic [15:0] RESP_KEY_PROG   = 16'h0100;
  localparam logic [15:0] RESP_COUNTER    = 16'h0200;

  // Result codes.
  localparam logic [7:0]  RES_OK          = 8'h00;
  localparam logic [7:0]  RES_GENERAL     = 8'h01;
  localparam logic [7:0]  RES_WRITE_FAIL  = 8'h05;
  localparam logic [7:0]  RES_READ_FAIL   = 8'h06;
  localparam logic [7:0]  RES_NO_KEY      = 8'h07;
  localparam logic [7:0]  RES_EXPIRED     = 8'h80;
  localparam logic [31:0] COUNTER_RESET   = 32'h00000000;
  localparam logic [31:0] COUNTER_MAX     = 32'hFFFFFFFF;

  // Frame byte positions, highest byte sent first.
  localparam logic [9:0]  BYTE_LAST       = 10'h1FF;
  localparam logic [9:0]  BYTE_MAC_LO     = 10'h11C;
  localparam logic [9:0]  BYTE_MAC_HI     = 10'h13B;
  localparam logic [9:0]  BYTE_MSG_TOP    = 10'h11B;
  localparam logic [9:0]  BYTE_NONCE_LO   = 10'h00C;
  localparam logic [9:0]  BYTE_NONCE_HI   = 10'h01B;
  localparam logic [9:0]  BYTE_CNT_LO     = 10'h008;
  localparam logic [9:0]  BYTE_CNT_HI     = 10'h00B;
  localparam logic [9:0]  BYTE_RES        = 10'h002;

  // Beat numbers on the link.
  localparam logic [9:0]  RX_DATA_LAST    = 10'h1FF;
  localparam logic [9:0]  RX_END          = 10'h210;
  localparam logic [9:0]  TX_DATA_LAST    = 10'h200;
  localparam logic [9:0]  TX_CRC_LAST     = 10'h210;
  localparam logic [9:0]  TX_END          = 10'h211;
  localparam logic [4:0]  STAT_POSITIVE   = 5'h05;
  localparam logic [4:0]  STAT_NEGATIVE   = 5'h0B;
  localparam logic [2:0]  STAT_BITS       = 3'h5;
  localparam logic [15:0] CRC_POLY        = 16'h1021;

  // Timing.
  localparam int          PCLK_PERIOD_NS  = 25;
  localparam int          KEY_BUSY_NS     = 1000;
  localparam logic [7:0]  KEY_BUSY_CYC    = 8'((KEY_BUSY_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS);
  localparam logic [7:0]  SHORT_BUSY_CYC  = 8'h01;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RXWAIT = 3'b001,
    ST_RXDATA = 3'b010,
    ST_STATUS = 3'b011,
    ST_BUSY   = 3'b100,
    ST_TXDATA = 3'b101
  } rpka_state_t;

  typedef enum logic [1:0] {
    JOB_FAIL    = 2'b00,
    JOB_KEY     = 2'b01,
    JOB_COUNTER = 2'b10,
    JOB_RESULT  = 2'b11
  } rpka_job_t;

endpackage : rpka_pkg

// ### rpka_sync.sv
/*
  Two-stage synchroniser for a bundle of pins.
  Assumes the inputs are asynchronous to clk.
*/
`timescale 1ns/1ps
module rpka_sync (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rstn,
  // Pins in, synchronised copy out.
  input  wire logic [8:0] d,
  output logic      [8:0] q
);
  logic [8:0] meta;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= 9'h000;
      q    <= 9'h000;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : rpka_sync

// ### rpka_crc16.sv
/*
  Per-lane CRC16 for the 8 data lanes, one bit per lane per enable.
  Feeding the outgoing CRC bits back in shifts the remainder out.
*/
`timescale 1ns/1ps
module rpka_crc16 (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rstn,
  // Control and data.
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [7:0] din,
  // Lane state.
  output logic      [7:0] msb,
  output logic            zero
);
  logic [7:0] lane_zero;

  for (genvar i = 0; i < 8; i++)
  begin : g_lane
    logic [15:0] crc;
    wire         fb = crc[15] ^ din[i];

    always_ff @(posedge clk or negedge rstn)
    begin
      if (!rstn)
        crc <= 16'h0000;
      else if (clr)
        crc <= 16'h0000;
      else if (en)
        crc <= {crc[14:0], 1'b0} ^ (fb ? rpka_pkg::CRC_POLY : 16'h0000);
    end

    assign msb[i]       = crc[15];
    assign lane_zero[i] = (crc == 16'h0000);
  end

  assign zero = &lane_zero;
endmodule : rpka_crc16

// ### rpka_checker.sv
/*
  Port checker for the replay-protected engine.
  Assumes a bind onto rpka_engine, one clock domain.
*/
`timescale 1ns/1ps
module rpka_checker (
  // Clock and reset.
  input wire logic         pclk,
  input wire logic         presetn,
  // Watched ports.
  input wire logic         psel,
  input wire logic         penable,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr,
  input wire logic [7:0]   link_dat_oe,
  input wire logic         mac_start,
  input wire logic [255:0] mac_key,
  input wire logic         mac_byte_valid,
  input wire logic         mac_byte_last
);
  logic [9:0] n_mac;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_burst;
    mac_byte_valid [*8];
  endsequence
  // Counts hashed bytes since the last start.
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      n_mac <= 10'h000;
    else if (mac_start)
      n_mac <= 10'h000;
    else if (mac_byte_valid)
      n_mac <= n_mac + 10'h001;
  chk_apb_pulse: assert property (pready |=> !pready) else $error("pready too long");
  chk_apb_phase: assert property (pready |-> psel && penable) else $error("pready outside access");
  chk_err_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  chk_mac_burst: assert property (mac_start |=> s_burst) else $error("hash bytes not back to back");
  chk_mac_count: assert property (mac_byte_last |-> mac_byte_valid && n_mac == 10'h11B) else $error("hash length");
  chk_mac_key: assert property (mac_start |-> mac_key != 256'h0) else $error("hash without key");
  chk_key_once: assert property (n_mac != 10'h000 |=> $stable(mac_key)) else $error("key changed");
  chk_lane_oe: assert property (link_dat_oe inside {8'h00, 8'h01, 8'hFF}) else $error("lane enable");
endmodule : rpka_checker

// ### rpka_host.sv
/*
  Host link model: sends and collects 512-byte frames on 8 lanes.
  Assumes lanes are pulled up when nobody drives them.
*/
`timescale 1ns/1ps
module rpka_host (
  // Wire level.
  input  wire logic [7:0] lane,
  // Host drive.
  output logic            link_clk,
  output logic      [7:0] drv,
  output logic            drv_oe
);
  logic [7:0] fr [512];
  logic [7:0] smp;
  logic [4:0] stat;
  logic       busy;
  event       got;
  initial
  begin
    link_clk = 0;
    drv = 8'hFF;
    drv_oe = 0;
  end
  // The clock only runs inside tasks, so it stands still between frames; frames start off the system clock edge.
  task automatic beat(input logic [7:0] v);
    drv = v;
    #100;
    link_clk = 1;
    smp = lane;
    #100;
    link_clk = 0;
  endtask : beat
  task automatic send();
    logic [15:0] c [8];
    logic [7:0]  v;
    int          i, k;
    c = '{default: 16'h0};
    #5 drv_oe = 1;
    beat(8'h00);
    for (i = 511; i >= 0; i--)
    begin
      for (k = 0; k < 8; k++)
        c[k] = {c[k][14:0], 1'b0} ^ ((c[k][15] ^ fr[i][k]) ? 16'h1021 : 16'h0000);
      beat(fr[i]);
    end
    for (i = 15; i >= 0; i--)
    begin
      for (k = 0; k < 8; k++)
        v[k] = c[k][i];
      beat(v);
    end
    beat(8'hFF);
    drv_oe = 0;
    repeat (5)
    begin
      beat(8'hFF);
      stat = {stat[3:0], smp[0]};
    end
    busy = 0;
    do
    begin
      beat(8'hFF);
      busy |= !smp[0];
    end
    while (!smp[0]);
  endtask : send
  task automatic recv();
    int i;
    #5;
    do
      beat(8'hFF);
    while (smp !== 8'h00);
    for (i = 511; i >= 0; i--)
    begin
      beat(8'hFF);
      fr[i] = smp;
    end
    repeat (18) beat(8'hFF);
    ->got;
  endtask : recv
endmodule : rpka_host

// ### test_replay_protected_key_and_counter_access.sv
/*
  Bench: APB master, host link model and hash stub around the engine.
  Assumes rpka_pkg, rpka_host and rpka_checker are compiled first.
*/
`timescale 1ns/1ps
module test_replay_protected_key_and_counter_access;
  localparam logic [31:0] MW = 32'h5A3C1E0F;
  logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]   paddr = 8'h00, dout, doe, drv, lane, mac_byte;
  logic [31:0]  pwdata = 32'h0, prdata, nonce;
  logic         pready, pslverr, mac_start, mac_byte_valid, mac_byte_last, link_clk, drv_oe;
  logic         mac_done = 0, counter_inc = 0, key_store_fail = 0, counter_read_fail = 0;
  logic [255:0] mac_value = {8{MW}}, mac_key;
  logic [31:0]  exp_q [$];
  int           offs [5] = '{0, 8, 12, 28, 284};
  int           n_errors = 0, checks_done = 0, seed = 72;
  always #12.5 pclk = ~pclk;
  assign lane = (dout & doe) | (~doe & (drv_oe ? drv : 8'hFF));
  rpka_engine u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link_clk, .link_dat_in(lane), .link_dat_out(dout), .link_dat_oe(doe), .mac_start, .mac_key, .mac_byte,
    .mac_byte_valid, .mac_byte_last, .mac_done, .mac_value, .counter_inc, .key_store_fail,
    .counter_read_fail);
  rpka_host u_host (.lane, .link_clk, .drv, .drv_oe);
  always @(posedge pclk)
    mac_done <= mac_byte_last;
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic check(input logic [31:0] got);
    logic [31:0] e;
    e = exp_q.pop_front();
    checks_done++;
    if (got !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask : check
  function automatic logic [31:0] wd(input int b);
    return {u_host.fr[b + 3], u_host.fr[b + 2], u_host.fr[b + 1], u_host.fr[b]};
  endfunction : wd
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata[30:0]});
  always @(u_host.got)
    foreach (offs[j])
      check(wd(offs[j]));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
      @(posedge pclk);
    while (!pready);
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(0, a, 32'h0);
  endtask : rd
  task automatic req(input logic [31:0] cnt, input logic [15:0] t, input logic b);
    apb(1, rpka_pkg::REG_BLKCNT, cnt);
    apb(1, rpka_pkg::REG_CMD, {26'h0, rpka_pkg::CMD_WRITE_MULTI});
    for (int i = 0; i < 512; i++)
      u_host.fr[i] = ((t == rpka_pkg::REQ_KEY_PROG && i > 283 && i < 316) ||
        (t == rpka_pkg::REQ_COUNTER && i > 11 && i < 28)) ? 8'($random(seed)) : 8'h00;
    u_host.fr[0] = t[7:0];
    u_host.fr[1] = t[15:8];
    nonce = wd(12);
    exp_q.push_back({26'h0, b, rpka_pkg::STAT_POSITIVE});
    u_host.send();
    check({26'h0, u_host.busy, u_host.stat});
  endtask : req
  task automatic rsp(input logic [15:0] t, input logic [7:0] r, input logic [31:0] c, n, m);
    apb(1, rpka_pkg::REG_BLKCNT, 32'h1);
    exp_q.push_back({8'h0, r, t});
    exp_q.push_back(c);
    exp_q.push_back(n);
    exp_q.push_back(32'h0);
    exp_q.push_back(m);
    apb(1, rpka_pkg::REG_CMD, {26'h0, rpka_pkg::CMD_READ_MULTI});
    u_host.recv();
  endtask : rsp
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(rpka_pkg::REG_PART, 32'(rpka_pkg::PART_RESET));
    rd(8'h20, 32'h80000000);
    apb(1, rpka_pkg::REG_PART, 32'(rpka_pkg::PART_REPLAY));
    req(32'h1, rpka_pkg::REQ_RESULT, 0);
    rsp(rpka_pkg::RESP_KEY_PROG, rpka_pkg::RES_NO_KEY, 0, 0, 0);
    req(32'h1, rpka_pkg::REQ_KEY_PROG, 0);
    req(32'h1, rpka_pkg::REQ_RESULT, 0);
    rsp(rpka_pkg::RESP_KEY_PROG, rpka_pkg::RES_GENERAL, 0, 0, 0);
    key_store_fail <= 1;
    req(32'h80000001, rpka_pkg::REQ_KEY_PROG, 1);
    req(32'h1, rpka_pkg::REQ_RESULT, 0);
    rsp(rpka_pkg::RESP_KEY_PROG, rpka_pkg::RES_WRITE_FAIL, 0, 0, 0);
    key_store_fail <= 0;
    req(32'h80000001, rpka_pkg::REQ_KEY_PROG, 1);
    req(32'h1, rpka_pkg::REQ_RESULT, 0);
    rsp(rpka_pkg::RESP_KEY_PROG, rpka_pkg::RES_OK, 0, 0, 0);
    rd(rpka_pkg::REG_STATUS, 32'h8);
    counter_inc <= 1;
    repeat (3) @(posedge pclk);
    counter_inc <= 0;
    rd(rpka_pkg::REG_COUNTER, 32'h3);
    req(32'h1, rpka_pkg::REQ_COUNTER, 1);
    rsp(rpka_pkg::RESP_COUNTER, rpka_pkg::RES_OK, 32'h3, nonce, MW);
    counter_read_fail <= 1;
    req(32'h1, rpka_pkg::REQ_COUNTER, 1);
    rsp(rpka_pkg::RESP_COUNTER, rpka_pkg::RES_READ_FAIL, 32'h3, nonce, MW);
    apb(1, rpka_pkg::REG_PART, 32'h0);
    end_sim();
  end
  initial
  begin
    #2500000;
    n_errors++;
    end_sim();
  end
endmodule : test_replay_protected_key_and_counter_access
bind rpka_engine rpka_checker u_chk (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
  .link_dat_oe, .mac_start, .mac_key, .mac_byte_valid, .mac_byte_last);
